// *** hw/sls_pkg.sv ***
package sls_pkg;

    // serial word framing, request, lock and recovered clock counts
    localparam int unsigned      WORD_BITS   = 12;
    localparam logic [3:0]       BIT_LAST    = 4'hB;
    localparam logic [11:0]      SYNC_WORD   = 12'hFC0;
    localparam logic [10:0]      SYNC_WORDS  = 11'h402;
    localparam logic [2:0]       REQ_EDGES   = 3'h7;
    localparam logic [2:0]       TX_INIT_EDGES = 3'h4;
    localparam logic [2:0]       LOCK_WORDS  = 3'h4;
    localparam logic [1:0]       RMT_WORDS   = 2'h2;
    localparam logic [2:0]       RCLK_HIGH   = 3'h6;

    // synchronised pin positions
    localparam int unsigned      PIN_WCLK    = 5;
    localparam int unsigned      PIN_REQ_A   = 4;
    localparam int unsigned      PIN_REQ_B   = 3;
    localparam int unsigned      PIN_TX_EN   = 2;
    localparam int unsigned      PIN_RX_EN   = 1;
    localparam int unsigned      PIN_SER     = 0;
    localparam int unsigned      PIN_COUNT   = 6;

    typedef struct packed {
        logic        wclk_prev;
        logic [2:0]  init_cnt;
        logic        ready;
        logic [2:0]  req_cnt;
        logic        pend;
        logic        sync;
        logic [10:0] burst;
        logic [3:0]  bit_cnt;
        logic [11:0] shreg;
    } sls_tx_state_t;

    typedef struct packed {
        logic        prev;
        logic [3:0]  bit_cnt;
        logic [11:0] shreg;
        logic [3:0]  rises;
        logic [1:0]  rmt_cnt;
        logic        have_cand;
        logic [3:0]  cand;
        logic [2:0]  hit;
        logic [2:0]  miss;
        logic        locked;
        logic [9:0]  data;
        logic        rclk;
        logic [2:0]  rclk_cnt;
    } sls_rx_state_t;

    typedef struct packed {
        sls_tx_state_t tx;
        sls_rx_state_t rx;
    } sls_state_t;

    localparam sls_state_t STATE_RST = '0;

endpackage

// *** hw/sls_sync_request_b.sv ***
`timescale 1ns/10ps
`default_nettype none

module sls_sync_request_b #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    // pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

`default_nettype wire

// *** hw/sls_link_sync.sv ***
// Function
// - request held over 7 word clocks sends exactly 1026 sync words.
// - sync word is six ones then six zeros.
// - lock indicator stays high while still acquiring.
// - when locked, parallel outputs carry recovered words.
// - receiver locks on random data, starting at input transitions.
// - detect more than one rising edge per word over two words running.
// - repetitive pattern keeps lock indicator high until pattern changes.
// - lock after boundary found at same position four words running.
// - boundary missing four words running drops lock, hunting restarts.
// - once locked, repetitive data does not disturb lock.
// - unlocked receiver floats data outputs and recovered word clock.
// - serial output floats until the word clock is acquired.
// - enable-low floats outputs while lock is kept.
// - each word framed by high start bit and low stop bit.
// - twelve bits per word, ten data plus two framing.
// - parallel inputs ignored while a sync burst runs.
`timescale 1ns/10ps
`default_nettype none

module sls_link_sync (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    // transmit side pins
    input  wire logic       transmit_word_clock_i,
    input  wire logic       sync_request_a_i,
    input  wire logic       sync_request_b_i,
    input  wire logic       tx_enable_i,
    input  wire logic [9:0] tx_data_i,
    output logic            tx_serial_o,
    output logic            tx_serial_oe_o,
    output logic            tx_sync_active_o,
    // receive side pins
    input  wire logic       rx_enable_i,
    input  wire logic       rx_serial_i,
    output logic            lock_n_o,
    output logic [9:0]      rx_data_o,
    output logic            rx_data_oe_o,
    output logic            rx_word_clock_o,
    output logic            rx_word_clock_oe_o
);

    sls_pkg::sls_state_t st_reg;
    sls_pkg::sls_state_t st_next;
    logic [sls_pkg::PIN_COUNT-1:0] pins;
    logic                          wrise;
    logic                          req;
    logic                          rise;
    logic [3:0]                    word_rises;
    logic                          repetitive_multi_transition;

    sls_sync_request_b #(
        .W (sls_pkg::PIN_COUNT)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({transmit_word_clock_i, sync_request_a_i,
                     sync_request_b_i, tx_enable_i, rx_enable_i,
                     rx_serial_i}),
        .sync_o    (pins)
    );

    always_comb begin
        st_next    = st_reg;
        wrise      = pins[sls_pkg::PIN_WCLK] & ~st_reg.tx.wclk_prev;
        req        = pins[sls_pkg::PIN_REQ_A] | pins[sls_pkg::PIN_REQ_B];
        rise       = pins[sls_pkg::PIN_SER] & ~st_reg.rx.prev;
        word_rises = st_reg.rx.rises + {3'h0, rise};
        repetitive_multi_transition        = (st_reg.rx.rmt_cnt == sls_pkg::RMT_WORDS);

        // transmit: word clock acquisition before driving the line
        st_next.tx.wclk_prev = pins[sls_pkg::PIN_WCLK];
        if (!st_reg.tx.ready && wrise) begin
            st_next.tx.init_cnt = st_reg.tx.init_cnt + 3'h1;
            if (st_reg.tx.init_cnt == sls_pkg::TX_INIT_EDGES - 3'h1) begin
                st_next.tx.ready = 1'b1;
            end
        end

        // transmit: one bit per clock, reload after the last bit
        st_next.tx.shreg = {st_reg.tx.shreg[10:0], 1'b0};
        if (st_reg.tx.bit_cnt == sls_pkg::BIT_LAST) begin
            st_next.tx.bit_cnt = 4'h0;
            if (st_reg.tx.pend || st_reg.tx.burst != 11'h000) begin
                st_next.tx.shreg = sls_pkg::SYNC_WORD;
                st_next.tx.sync  = 1'b1;
                st_next.tx.pend  = 1'b0;
                st_next.tx.burst = st_reg.tx.pend ?
                    sls_pkg::SYNC_WORDS - 11'h001 :
                    st_reg.tx.burst - 11'h001;
            end else begin
                st_next.tx.shreg = {1'b1, tx_data_i, 1'b0};
                st_next.tx.sync  = 1'b0;
            end
        end else begin
            st_next.tx.bit_cnt = st_reg.tx.bit_cnt + 4'h1;
        end

        // request counted in word clocks; re-arms so a held request
        // (lock tied back) keeps bursting
        if (!req) begin
            st_next.tx.req_cnt = 3'h0;
        end else if (wrise) begin
            if (st_reg.tx.req_cnt == sls_pkg::REQ_EDGES - 3'h1) begin
                st_next.tx.req_cnt = 3'h0;
                st_next.tx.pend    = 1'b1;
            end else begin
                st_next.tx.req_cnt = st_reg.tx.req_cnt + 3'h1;
            end
        end

        // receive: sample one bit per clock
        st_next.rx.prev  = pins[sls_pkg::PIN_SER];
        st_next.rx.shreg = {st_reg.rx.shreg[10:0], pins[sls_pkg::PIN_SER]};
        if (st_reg.rx.bit_cnt == sls_pkg::BIT_LAST) begin
            st_next.rx.bit_cnt = 4'h0;
            st_next.rx.rises   = 4'h0;
            if (word_rises > 4'h1) begin
                if (!repetitive_multi_transition) begin
                    st_next.rx.rmt_cnt = st_reg.rx.rmt_cnt + 2'h1;
                end
            end else begin
                st_next.rx.rmt_cnt = 2'h0;
            end
        end else begin
            st_next.rx.bit_cnt = st_reg.rx.bit_cnt + 4'h1;
            st_next.rx.rises   = word_rises;
        end

        // receive: boundary hunt and lock tracking
        if (!st_reg.rx.locked) begin
            if (!st_reg.rx.have_cand) begin
                if (rise) begin
                    st_next.rx.have_cand = 1'b1;
                    st_next.rx.cand      = st_reg.rx.bit_cnt;
                    st_next.rx.hit       = 3'h1;
                end
            end else if (st_reg.rx.bit_cnt == st_reg.rx.cand) begin
                if (!rise) begin
                    st_next.rx.have_cand = 1'b0;
                    st_next.rx.hit       = 3'h0;
                end else if (st_reg.rx.hit == sls_pkg::LOCK_WORDS - 3'h1) begin
                    // hit count parks here while the pattern repeats
                    if (!repetitive_multi_transition) begin
                        st_next.rx.locked = 1'b1;
                        st_next.rx.miss   = 3'h0;
                    end
                end else begin
                    st_next.rx.hit = st_reg.rx.hit + 3'h1;
                end
            end
        end else if (st_reg.rx.bit_cnt == st_reg.rx.cand) begin
            // repetitive data ignored here
            if (rise) begin
                st_next.rx.miss = 3'h0;
            end else if (st_reg.rx.miss == sls_pkg::LOCK_WORDS - 3'h1) begin
                st_next.rx.locked    = 1'b0;
                st_next.rx.have_cand = 1'b0;
                st_next.rx.hit       = 3'h0;
            end else begin
                st_next.rx.miss = st_reg.rx.miss + 3'h1;
            end
        end

        // word captured on every boundary; outputs gated by lock
        if (st_reg.rx.have_cand && rise &&
            st_reg.rx.bit_cnt == st_reg.rx.cand) begin
            st_next.rx.data     = st_reg.rx.shreg[10:1];
            st_next.rx.rclk     = 1'b1;
            st_next.rx.rclk_cnt = 3'h0;
        end else if (st_reg.rx.rclk) begin
            if (st_reg.rx.rclk_cnt == sls_pkg::RCLK_HIGH - 3'h1) begin
                st_next.rx.rclk = 1'b0;
            end else begin
                st_next.rx.rclk_cnt = st_reg.rx.rclk_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_reg <= sls_pkg::STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_serial_o        = st_reg.tx.shreg[11];
    assign tx_serial_oe_o     = st_reg.tx.ready & pins[sls_pkg::PIN_TX_EN];
    assign tx_sync_active_o   = st_reg.tx.sync;
    assign lock_n_o           = ~st_reg.rx.locked;
    assign rx_data_o          = st_reg.rx.data;
    // enable low floats outputs but lock state survives
    assign rx_data_oe_o       = st_reg.rx.locked &
                                pins[sls_pkg::PIN_RX_EN];
    assign rx_word_clock_o    = st_reg.rx.rclk;
    assign rx_word_clock_oe_o = rx_data_oe_o;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_lock_ready;
        st_reg.rx.hit == sls_pkg::LOCK_WORDS - 3'h1 && !repetitive_multi_transition && rise;
    endsequence

    property p_burst_len;
        $rose(st_reg.tx.sync) |-> st_reg.tx.burst == 11'h401;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("sync burst length wrong");

    property p_sync_word;
        $rose(st_reg.tx.sync) |-> st_reg.tx.shreg == 12'hFC0
            ##6 tx_serial_o == 1'b0;
    endproperty
    a_sync_word: assert property (p_sync_word)
        else $error("sync word shape wrong");

    property p_lock_high;
        !st_reg.rx.locked |-> lock_n_o && !rx_data_oe_o;
    endproperty
    a_lock_high: assert property (p_lock_high)
        else $error("lock shown while acquiring");

    property p_lock_entry;
        $rose(st_reg.rx.locked) |->
            $past(st_reg.rx.hit) == 3'h3 && $past(st_reg.rx.have_cand);
    endproperty
    a_lock_entry: assert property (p_lock_entry)
        else $error("lock without four boundaries");

    property p_rmt_block;
        !st_reg.rx.locked && repetitive_multi_transition |=> !st_reg.rx.locked;
    endproperty
    a_rmt_block: assert property (p_rmt_block)
        else $error("lock taken during repetitive pattern");

    property p_lock_take;
        !st_reg.rx.locked && st_reg.rx.have_cand &&
        st_reg.rx.bit_cnt == st_reg.rx.cand ##0 s_lock_ready
            |=> st_reg.rx.locked ##0 !lock_n_o;
    endproperty
    a_lock_take: assert property (p_lock_take)
        else $error("lock not declared");

    property p_lock_drop;
        $fell(st_reg.rx.locked) |->
            $past(st_reg.rx.miss) == 3'h3 && !st_reg.rx.have_cand;
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("lock dropped without four misses");

    property p_tx_float;
        !st_reg.tx.ready |-> !tx_serial_oe_o;
    endproperty
    a_tx_float: assert property (p_tx_float)
        else $error("serial output driven before ready");

    property p_bit_wrap;
        st_reg.tx.bit_cnt == 4'hB |=> st_reg.tx.bit_cnt == 4'h0
            ##11 st_reg.tx.bit_cnt == 4'hB;
    endproperty
    a_bit_wrap: assert property (p_bit_wrap)
        else $error("word is not twelve bits");

    property p_frame;
        st_reg.tx.bit_cnt == 4'hB && !st_next.tx.sync |=>
            tx_serial_o ##11 !tx_serial_o;
    endproperty
    a_frame: assert property (p_frame)
        else $error("start or stop bit wrong");

endmodule

`default_nettype wire

// *** dv/sls_peer_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module sls_peer_model (
    // clock
    input  wire logic        ref_clk_i,
    // bench control
    input  wire logic        mode_i,
    input  wire logic [11:0] pattern_i,
    // link
    input  wire logic        tx_serial_i,
    input  wire logic        tx_serial_oe_i,
    output logic             word_clock_o,
    output logic             serial_o
);
    logic [3:0] pos;

    // free running, phase unrelated to the reference clock
    initial begin
        word_clock_o = 1'b0;
        #7;
        forever #80 word_clock_o = ~word_clock_o;
    end

    initial begin
        pos = 4'h0;
        serial_o = 1'b0;
    end

    always @(negedge ref_clk_i) begin
        pos <= (pos == 4'hB) ? 4'h0 : pos + 4'h1;
        if (mode_i) begin
            serial_o <= pattern_i[4'hB - pos];
        end else if (tx_serial_oe_i) begin
            serial_o <= tx_serial_i;
        end else begin
            // released line has no stable level
            serial_o <= ~serial_o;
        end
    end
endmodule

`default_nettype wire

// *** dv/tb_sls_link_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_sls_link_sync;
    logic        ref_clk_i, sys_rst_i, wclk, req_a, req_b, req_b_pin;
    logic        tie_lock, tx_en, rx_en, rx_ser, mode, prev, seen;
    logic        tx_ser, tx_oe, tx_act, lock_n, rd_oe, rclk, rclk_oe;
    logic [9:0]  tx_data, rdata;
    logic [11:0] pat;
    logic [15:0] n, ones, rises;
    int          fail_count, check_count, i;
    int          cyc = 0;

    // lock indicator may drive the second request
    assign req_b_pin = tie_lock ? lock_n : req_b;

    sls_link_sync i_sls_link_sync (
        .ref_clk_i            (ref_clk_i),
        .sys_rst_i            (sys_rst_i),
        .transmit_word_clock_i(wclk),
        .sync_request_a_i     (req_a),
        .sync_request_b_i     (req_b_pin),
        .tx_enable_i          (tx_en),
        .tx_data_i            (tx_data),
        .tx_serial_o          (tx_ser),
        .tx_serial_oe_o       (tx_oe),
        .tx_sync_active_o     (tx_act),
        .rx_enable_i          (rx_en),
        .rx_serial_i          (rx_ser),
        .lock_n_o             (lock_n),
        .rx_data_o            (rdata),
        .rx_data_oe_o         (rd_oe),
        .rx_word_clock_o      (rclk),
        .rx_word_clock_oe_o   (rclk_oe)
    );

    sls_peer_model i_sls_peer_model (
        .ref_clk_i     (ref_clk_i),
        .mode_i        (mode),
        .pattern_i     (pat),
        .tx_serial_i   (tx_ser),
        .tx_serial_oe_i(tx_oe),
        .word_clock_o  (wclk),
        .serial_o      (rx_ser)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    task report_and_stop;
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            $display("BAD timeout exp done got hang");
            report_and_stop;
        end
    end

    task check_flag(string nm, logic e, logic g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask

    task check_val(string nm, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task wait_lock(logic v, int lim);
        i = 0;
        while (lock_n !== v && i < lim) begin
            @(negedge ref_clk_i);
            i++;
        end
        check_flag("lock_n", v, lock_n);
    endtask

    task hold_lock(logic v, int len);
        seen = 1'b0;
        repeat (len) begin
            @(negedge ref_clk_i);
            if (lock_n !== v) seen = 1'b1;
        end
        check_flag("lock_moved", 1'b0, seen);
    endtask

    task t_reset;
        check_flag("lock_n", 1'b1, lock_n);
        check_flag("rx_oe", 1'b0, rd_oe);
        check_flag("rclk_oe", 1'b0, rclk_oe);
        check_flag("tx_oe", 1'b0, tx_oe);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check_flag("tx_oe", 1'b0, tx_oe);
        $display("test reset done");
    endtask

    task t_lock;
        wait_lock(1'b0, 400);
        repeat (40) @(negedge ref_clk_i);
        check_val("rx_data", 16'h03F0, {6'h00, rdata});
        check_flag("rx_oe", 1'b1, rd_oe);
        check_flag("rclk_oe", 1'b1, rclk_oe);
        check_flag("tx_oe", 1'b1, tx_oe);
        // one boundary per word, recovered clock high half of each word
        n = 16'h0000;
        repeat (24) begin
            @(negedge ref_clk_i);
            n = n + {15'h0000, rclk};
        end
        check_val("rclk_high", 16'h000C, n);
        // short float of both sides, too brief for four misses
        rx_en = 1'b0;
        tx_en = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        check_flag("rx_oe", 1'b0, rd_oe);
        check_flag("rclk_oe", 1'b0, rclk_oe);
        check_flag("tx_oe", 1'b0, tx_oe);
        check_flag("lock_n", 1'b0, lock_n);
        rx_en = 1'b1;
        tx_en = 1'b1;
        $display("test lock done");
    endtask

    task t_rmt_locked;
        // alternating data puts a rise at every other bit
        tx_data = 10'h155;
        hold_lock(1'b0, 600);
        check_val("rx_data", 16'h0155, {6'h00, rdata});
        tx_data = 10'h3F0;
        $display("test rmt locked done");
    endtask

    task t_drop;
        mode = 1'b1;
        pat = 12'h000;
        hold_lock(1'b0, 24);
        wait_lock(1'b1, 60);
        check_flag("rx_oe", 1'b0, rd_oe);
        check_flag("rclk_oe", 1'b0, rclk_oe);
        $display("test drop done");
    endtask

    task t_rmt_block;
        pat = 12'hCC0;
        hold_lock(1'b1, 600);
        // new boundary position, so a full hunt is needed
        pat = 12'h3F0;
        hold_lock(1'b1, 30);
        wait_lock(1'b0, 120);
        $display("test rmt block done");
    endtask

    task t_burst(logic sel);
        tx_data = 10'h2AA;
        req_a = ~sel;
        req_b = sel;
        seen = 1'b0;
        repeat (40) @(negedge ref_clk_i);
        req_a = 1'b0;
        req_b = 1'b0;
        repeat (300) begin
            @(negedge ref_clk_i);
            if (tx_act !== 1'b0) seen = 1'b1;
        end
        check_flag("short_req", 1'b0, seen);
        req_a = ~sel;
        req_b = sel;
        i = 0;
        prev = tx_ser;
        // request held until the burst shows, so no sync word goes uncounted
        while (tx_act !== 1'b1 && i < 200) begin
            prev = tx_ser;
            @(negedge ref_clk_i);
            i++;
        end
        req_a = 1'b0;
        req_b = 1'b0;
        check_flag("sync_wait", 1'b1, (i >= 48) && (i < 90));
        n = 16'h0000;
        ones = 16'h0000;
        rises = 16'h0000;
        while (tx_act === 1'b1 && n < 16'h3200) begin
            ones = ones + {15'h0000, tx_ser};
            rises = rises + {15'h0000, tx_ser & ~prev};
            prev = tx_ser;
            n = n + 16'h0001;
            @(negedge ref_clk_i);
        end
        check_val("burst_cycles", 16'h3018, n);
        check_val("burst_words", 16'h0402, rises);
        check_val("burst_ones", 16'h180C, ones);
        tx_data = 10'h3F0;
        $display("test burst done");
    endtask

    task t_auto;
        tie_lock = 1'b1;
        mode = 1'b1;
        pat = 12'h000;
        i = 0;
        while (tx_act !== 1'b1 && i < 400) begin
            @(negedge ref_clk_i);
            i++;
        end
        check_flag("auto_sync", 1'b1, tx_act);
        mode = 1'b0;
        wait_lock(1'b0, 300);
        tie_lock = 1'b0;
        $display("test auto sync done");
    endtask

    initial begin
        sys_rst_i = 1'b1;
        req_a = 1'b0;
        req_b = 1'b0;
        tie_lock = 1'b0;
        tx_en = 1'b1;
        rx_en = 1'b1;
        tx_data = 10'h3F0;
        mode = 1'b0;
        pat = 12'h000;
        fail_count = 0;
        check_count = 0;
        repeat (6) @(negedge ref_clk_i);
        t_reset;
        t_lock;
        t_rmt_locked;
        t_drop;
        t_rmt_block;
        t_burst(1'b0);
        t_burst(1'b1);
        t_auto;
        report_and_stop;
    end
endmodule

`default_nettype wire
